// ---- tpg_map.svh ----
// Register offsets, field positions and reset values of the pattern generator.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
`ifndef TPG_MAP_SVH
`define TPG_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TPG_OFS_CTRL   8'h00
`define TPG_OFS_DATA   8'h04
`define TPG_OFS_GREEN  8'h08
`define TPG_OFS_RED    8'h0c
`define TPG_OFS_BLUE   8'h10
`define TPG_OFS_BARW   8'h14
`define TPG_OFS_STAT   8'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define TPG_CTRL_EN    0
`define TPG_CTRL_MLSB  4
`define TPG_STAT_BUSY  0
`define TPG_STAT_FRAME 1
`define TPG_STAT_ACT   2
`define TPG_RST_EN     1'h0
`define TPG_RST_MODE   4'h0
`define TPG_RST_LEVEL  12'h000
`define TPG_RST_BARW   12'h000
`define TPG_PIX_MAX    12'hfff
`define TPG_WALK_FIRST 12'h001
`define TPG_CFG_W      65

`endif

// ---- tpg_pkg.sv ----
// Types shared by the pattern generator.
// Assumes nothing beyond a SystemVerilog tool.
package tpg_pkg;

   // ----------------------------------------
   // Pattern select encoding
   // ----------------------------------------
   typedef enum logic [3:0] {
      TPG_FIELD   = 4'h0,
      TPG_HGRAD   = 4'h1,
      TPG_VGRAD   = 4'h2,
      TPG_DIAG    = 4'h3,
      TPG_CLASSIC = 4'h4,
      TPG_WALK    = 4'h5,
      TPG_HBAR    = 4'h6,
      TPG_VBAR    = 4'h7,
      TPG_CBAR    = 4'h8
   } tpg_mode_t;

   // ----------------------------------------
   // Config hand-over state
   // ----------------------------------------
   typedef enum logic [1:0] {
      TPG_XF_IDLE = 2'b01,
      TPG_XF_BUSY = 2'b10
   } tpg_xfer_t;

endpackage

// ---- tpg_core.sv ----
// Test-pattern injector for the sensor pixel pipeline, with its register slave.
// Assumes a Wishbone master on i_ref_clk and sensor timing on i_pix_clk.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tpg_map.svh"

module tpg_core #(
   parameter int CB_SHIFT = 8
) (
   // Register side
   input  wire logic        i_ref_clk,
   input  wire logic        i_nrst,
   // Wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [31:0] i_wb_dat,
   input  wire logic [3:0]  i_wb_sel,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   // Sensor stream
   input  wire logic        i_pix_clk,
   input  wire logic [11:0] i_sns_data,
   input  wire logic        i_sns_frame_valid,
   input  wire logic        i_sns_line_valid,
   input  wire logic        i_sns_dark,
   // Receiver stream
   output logic      [11:0] o_pix_data,
   output logic             o_frame_valid,
   output logic             o_line_valid
);

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic                    wb_req;
   logic                    wr_go;
   logic                    ctrl_en;
   logic [3:0]              ctrl_mode;
   logic [11:0]             reg_data;
   logic [11:0]             reg_green;
   logic [11:0]             reg_red;
   logic [11:0]             reg_blue;
   logic [11:0]             reg_barw;
   logic                    cfg_dirty;
   logic                    cfg_wr;
   tpg_pkg::tpg_xfer_t      xf_state;
   logic [`TPG_CFG_W-1:0]   snap;
   logic                    req_tog;
   logic                    ack_s1, ack_s2, ack_s3;
   logic                    frm_s1, frm_s2;
   logic                    act_s1, act_s2;
   logic [31:0]             next_rd;
   logic                    pix_ack_tog;
   logic                    act_en;

   function automatic logic [11:0] lanes(input logic [11:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      lanes = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   assign wb_req = i_wb_cyc & i_wb_stb;
   // Writes commit on the edge that the master sees ack
   assign wr_go  = wb_req & i_wb_we & o_wb_ack;
   assign cfg_wr = wr_go & (i_wb_adr != `TPG_OFS_STAT);

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wb_ack <= 1'b0;
      end else begin
         o_wb_ack <= wb_req & ~o_wb_ack;
      end
   end

   always_comb begin
      next_rd = 32'h0000_0000;
      case (i_wb_adr)
         `TPG_OFS_CTRL: begin
            next_rd[`TPG_CTRL_EN] = ctrl_en;
            next_rd[`TPG_CTRL_MLSB +: 4] = ctrl_mode;
         end
         `TPG_OFS_DATA:  next_rd[11:0] = reg_data;
         `TPG_OFS_GREEN: next_rd[11:0] = reg_green;
         `TPG_OFS_RED:   next_rd[11:0] = reg_red;
         `TPG_OFS_BLUE:  next_rd[11:0] = reg_blue;
         `TPG_OFS_BARW:  next_rd[11:0] = reg_barw;
         `TPG_OFS_STAT: begin
            next_rd[`TPG_STAT_BUSY]  = cfg_dirty | (xf_state == tpg_pkg::TPG_XF_BUSY);
            next_rd[`TPG_STAT_FRAME] = frm_s2;
            next_rd[`TPG_STAT_ACT]   = act_s2;
         end
         default: next_rd = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wb_dat <= 32'h0000_0000;
      end else if (wb_req & ~o_wb_ack & ~i_wb_we) begin
         o_wb_dat <= next_rd;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_en   <= `TPG_RST_EN;
         ctrl_mode <= `TPG_RST_MODE;
         reg_data  <= `TPG_RST_LEVEL;
         reg_green <= `TPG_RST_LEVEL;
         reg_red   <= `TPG_RST_LEVEL;
         reg_blue  <= `TPG_RST_LEVEL;
         reg_barw  <= `TPG_RST_BARW;
      end else if (wr_go) begin
         case (i_wb_adr)
            `TPG_OFS_CTRL: begin
               if (i_wb_sel[0]) begin
                  ctrl_en   <= i_wb_dat[`TPG_CTRL_EN];
                  ctrl_mode <= i_wb_dat[`TPG_CTRL_MLSB +: 4];
               end
            end
            `TPG_OFS_DATA:  reg_data  <= lanes(reg_data, i_wb_dat, i_wb_sel);
            `TPG_OFS_GREEN: reg_green <= lanes(reg_green, i_wb_dat, i_wb_sel);
            `TPG_OFS_RED:   reg_red   <= lanes(reg_red, i_wb_dat, i_wb_sel);
            `TPG_OFS_BLUE:  reg_blue  <= lanes(reg_blue, i_wb_dat, i_wb_sel);
            `TPG_OFS_BARW:  reg_barw  <= lanes(reg_barw, i_wb_dat, i_wb_sel);
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Config hand-over to the pixel domain
   // ----------------------------------------
   // Snapshot stays frozen until the pixel side acknowledges it
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         xf_state  <= tpg_pkg::TPG_XF_IDLE;
         cfg_dirty <= 1'b0;
         snap      <= '0;
         req_tog   <= 1'b0;
      end else begin
         case (xf_state)
            tpg_pkg::TPG_XF_IDLE: begin
               if (cfg_dirty) begin
                  snap     <= {ctrl_en, ctrl_mode, reg_data, reg_green,
                               reg_red, reg_blue, reg_barw};
                  req_tog  <= ~req_tog;
                  xf_state <= tpg_pkg::TPG_XF_BUSY;
               end
            end
            tpg_pkg::TPG_XF_BUSY: begin
               if (ack_s2 ^ ack_s3) begin
                  xf_state <= tpg_pkg::TPG_XF_IDLE;
               end
            end
            default: xf_state <= tpg_pkg::TPG_XF_IDLE;
         endcase
         // A write in the snapshot cycle keeps the flag set
         if (cfg_wr) begin
            cfg_dirty <= 1'b1;
         end else if (xf_state == tpg_pkg::TPG_XF_IDLE) begin
            cfg_dirty <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {ack_s1, ack_s2, ack_s3} <= 3'h0;
         {frm_s1, frm_s2}         <= 2'h0;
         {act_s1, act_s2}         <= 2'h0;
      end else begin
         {ack_s1, ack_s2, ack_s3} <= {pix_ack_tog, ack_s1, ack_s2};
         {frm_s1, frm_s2}         <= {o_frame_valid, frm_s1};
         {act_s1, act_s2}         <= {act_en, act_s1};
      end
   end

   // ----------------------------------------
   // Pixel domain reset and config capture
   // ----------------------------------------
   logic [1:0]              prst;
   logic                    pix_nrst;
   logic                    req_s1, req_s2, req_s3;
   logic [`TPG_CFG_W-1:0]   stage;
   logic [`TPG_CFG_W-1:0]   act;
   logic [3:0]              act_mode_raw;
   tpg_pkg::tpg_mode_t      act_mode;
   logic [11:0]             a_data, a_green, a_red, a_blue, a_barw;

   always_ff @(posedge i_pix_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prst <= 2'h0;
      end else begin
         prst <= {prst[0], 1'b1};
      end
   end
   assign pix_nrst = prst[1];

   always_ff @(posedge i_pix_clk or negedge pix_nrst) begin
      if (!pix_nrst) begin
         {req_s1, req_s2, req_s3} <= 3'h0;
         pix_ack_tog <= 1'b0;
         stage       <= '0;
      end else begin
         {req_s1, req_s2, req_s3} <= {req_tog, req_s1, req_s2};
         if (req_s2 ^ req_s3) begin
            stage       <= snap;
            pix_ack_tog <= ~pix_ack_tog;
         end
      end
   end

   // New settings land only while frame valid is low
   always_ff @(posedge i_pix_clk or negedge pix_nrst) begin
      if (!pix_nrst) begin
         act <= '0;
      end else if (!i_sns_frame_valid) begin
         act <= stage;
      end
   end

   assign {act_en, act_mode_raw, a_data, a_green, a_red, a_blue, a_barw} = act;
   // Codes above 8 fall to the default branch of the pattern case
   assign act_mode = tpg_pkg::tpg_mode_t'(act_mode_raw);

   // ----------------------------------------
   // Position counters
   // ----------------------------------------
   logic        line_valid_d;
   logic        act_pix;
   logic        row_end;
   logic        line_act;
   logic [11:0] col;
   logic [11:0] row;
   logic        cpar, rpar;
   logic [11:0] walk;
   logic [11:0] barw_m1;
   logic [11:0] vcnt, hcnt;
   logic        vodd, hodd;

   assign act_pix = i_sns_line_valid & ~i_sns_dark;
   assign row_end = line_valid_d & ~i_sns_line_valid & line_act;
   assign barw_m1 = (a_barw == 12'h000) ? 12'h000 : a_barw - 12'h001;

   always_ff @(posedge i_pix_clk or negedge pix_nrst) begin
      if (!pix_nrst) begin
         line_valid_d <= 1'b0;
         line_act <= 1'b0;
         col      <= 12'h000;
         cpar     <= 1'b0;
      end else begin
         line_valid_d <= i_sns_line_valid;
         if (!i_sns_line_valid) begin
            line_act <= 1'b0;
            col      <= 12'h000;
            cpar     <= 1'b0;
         end else begin
            cpar <= ~cpar;
            if (act_pix) begin
               line_act <= 1'b1;
               col      <= col + 12'h001;
            end
         end
      end
   end

   always_ff @(posedge i_pix_clk or negedge pix_nrst) begin
      if (!pix_nrst) begin
         row  <= 12'h000;
         rpar <= 1'b0;
      end else if (!i_sns_frame_valid) begin
         row  <= 12'h000;
         rpar <= 1'b0;
      end else begin
         if (line_valid_d & ~i_sns_line_valid) begin
            rpar <= ~rpar;
         end
         if (row_end) begin
            row <= row + 12'h001;
         end
      end
   end

   always_ff @(posedge i_pix_clk or negedge pix_nrst) begin
      if (!pix_nrst) begin
         walk <= `TPG_WALK_FIRST;
      end else if (!i_sns_line_valid) begin
         walk <= `TPG_WALK_FIRST;
      end else if (act_pix) begin
         walk <= {walk[10:0], walk[11]};
      end
   end

   always_ff @(posedge i_pix_clk or negedge pix_nrst) begin
      if (!pix_nrst) begin
         vcnt <= 12'h000;
         vodd <= 1'b0;
      end else if (!i_sns_line_valid) begin
         vcnt <= 12'h000;
         vodd <= 1'b0;
      end else if (act_pix) begin
         if (vcnt >= barw_m1) begin
            vcnt <= 12'h000;
            vodd <= ~vodd;
         end else begin
            vcnt <= vcnt + 12'h001;
         end
      end
   end

   always_ff @(posedge i_pix_clk or negedge pix_nrst) begin
      if (!pix_nrst) begin
         hcnt <= 12'h000;
         hodd <= 1'b0;
      end else if (!i_sns_frame_valid) begin
         hcnt <= 12'h000;
         hodd <= 1'b0;
      end else if (row_end) begin
         if (hcnt >= barw_m1) begin
            hcnt <= 12'h000;
            hodd <= ~hodd;
         end else begin
            hcnt <= hcnt + 12'h001;
         end
      end
   end

   // ----------------------------------------
   // Pattern selection and launch
   // ----------------------------------------
   logic [11:0] clr_lvl;
   logic [2:0]  bar_rgb;
   logic        bar_bit;
   logic [11:0] pat;
   logic [11:0] next_pix;

   // Bayer order: green/red on even rows, blue/green on odd rows
   always_comb begin
      case ({rpar, cpar})
         2'b01:   clr_lvl = a_red;
         2'b10:   clr_lvl = a_blue;
         default: clr_lvl = a_green;
      endcase
   end

   // White, yellow, cyan, green, magenta, red, blue, black
   always_comb begin
      case (col[CB_SHIFT +: 3])
         3'h0:    bar_rgb = 3'h7;
         3'h1:    bar_rgb = 3'h6;
         3'h2:    bar_rgb = 3'h3;
         3'h3:    bar_rgb = 3'h2;
         3'h4:    bar_rgb = 3'h5;
         3'h5:    bar_rgb = 3'h4;
         3'h6:    bar_rgb = 3'h1;
         default: bar_rgb = 3'h0;
      endcase
      case ({rpar, cpar})
         2'b01:   bar_bit = bar_rgb[2];
         2'b10:   bar_bit = bar_rgb[0];
         default: bar_bit = bar_rgb[1];
      endcase
   end

   always_comb begin
      case (act_mode)
         tpg_pkg::TPG_HGRAD:   pat = col;
         tpg_pkg::TPG_VGRAD:   pat = row;
         tpg_pkg::TPG_DIAG:    pat = col + row;
         tpg_pkg::TPG_CLASSIC: pat = col[0] ? ~a_data : a_data;
         tpg_pkg::TPG_WALK:    pat = walk;
         tpg_pkg::TPG_HBAR:    pat = hodd ? a_blue : a_green;
         tpg_pkg::TPG_VBAR:    pat = vodd ? a_blue : a_green;
         tpg_pkg::TPG_CBAR:    pat = bar_bit ? `TPG_PIX_MAX : 12'h000;
         default:              pat = clr_lvl;
      endcase
      if (i_sns_dark) begin
         pat = clr_lvl;
      end
      next_pix = act_en ? pat : i_sns_data;
   end

   // Launch on the rising edge gives the receiver half a period on the fall
   always_ff @(posedge i_pix_clk or negedge pix_nrst) begin
      if (!pix_nrst) begin
         o_pix_data    <= 12'h000;
         o_frame_valid <= 1'b0;
         o_line_valid  <= 1'b0;
      end else begin
         o_pix_data    <= next_pix;
         o_frame_valid <= i_sns_frame_valid;
         o_line_valid  <= i_sns_line_valid;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   logic on_pix;
   assign on_pix = act_en & act_pix;

   sequence s_line_start;
      !i_sns_line_valid ##1 i_sns_line_valid;
   endsequence

   a_pass_through: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      !act_en |=> o_pix_data == $past(i_sns_data))
      else $error("sensor data not passed through");

   a_classic_alt: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      on_pix && act_mode == tpg_pkg::TPG_CLASSIC && col[0]
      |=> o_pix_data == ~$past(a_data))
      else $error("classic odd column wrong");

   a_field_green: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      on_pix && act_mode == tpg_pkg::TPG_FIELD && rpar == cpar
      |=> o_pix_data == $past(a_green))
      else $error("field green level wrong");

   a_cbar_white: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      on_pix && act_mode == tpg_pkg::TPG_CBAR && col[CB_SHIFT +: 3] == 3'h0
      |=> o_pix_data == `TPG_PIX_MAX)
      else $error("first colour bar not white");

   a_hgrad_step: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      on_pix && act_mode == tpg_pkg::TPG_HGRAD ##1 on_pix
      |=> o_pix_data == $past(o_pix_data) + 12'h001)
      else $error("horizontal gradient step wrong");

   a_diag_sum: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      on_pix && act_mode == tpg_pkg::TPG_DIAG
      |=> o_pix_data == 12'($past(col) + $past(row)))
      else $error("diagonal value wrong");

   // Leading dark pixels do not move the walk, so the first active one carries 1
   a_walk_first: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      on_pix && act_mode == tpg_pkg::TPG_WALK && col == 12'h000
      |=> o_pix_data == `TPG_WALK_FIRST)
      else $error("walking ones does not start at 1");

   a_dark_level: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      act_en && i_sns_dark && i_sns_line_valid && !rpar && cpar
      |=> o_pix_data == $past(a_red))
      else $error("dark red pixel level wrong");

   a_launch_sync: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      ##1 (o_line_valid == $past(i_sns_line_valid)
      && o_frame_valid == $past(i_sns_frame_valid)))
      else $error("valid flags not launched together");

   a_line_launch: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      s_line_start |=> $rose(o_line_valid))
      else $error("line valid not launched one cycle late");

   a_row_restart: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      !i_sns_frame_valid |=> row == 12'h000 && hodd == 1'b0)
      else $error("row counter not restarted");

   a_mode_frozen: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      i_sns_frame_valid |=> $stable(act))
      else $error("pattern changed inside a frame");

   a_vbar_flip: assert property (
      @(posedge i_pix_clk) disable iff (!pix_nrst)
      act_pix && vcnt >= barw_m1 |=> vodd != $past(vodd))
      else $error("vertical bar did not toggle");

   a_bus_ack: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      wb_req && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
      else $error("bus ack not a single cycle");

endmodule // tpg_core

// ---- tpg_rx.sv ----
// Receiver model that captures the generator's output stream.
// Assumes the stream launches on the rising edge of i_pix_clk.
`timescale 1ns/1ps

module tpg_rx (
   // Stream in
   input  wire logic        i_pix_clk,
   input  wire logic [11:0] i_pix_data,
   input  wire logic        i_frame_valid,
   input  wire logic        i_line_valid,
   // Captured copy
   output logic      [11:0] o_data,
   output logic             o_frame_valid,
   output logic             o_line_valid
);
   // ----------------------------------------
   // Capture
   // ----------------------------------------
   // Falling edge gives half a period of margin on each side
   always_ff @(negedge i_pix_clk) begin
      o_data        <= i_pix_data;
      o_frame_valid <= i_frame_valid;
      o_line_valid  <= i_line_valid;
   end
endmodule // tpg_rx

// ---- tb_image_test_pattern_generator.sv ----
// Self-checking bench for the pattern generator.
// Assumes tpg_core and the receiver model tpg_rx.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", n, e, g); end end

module tb_image_test_pattern_generator;
   localparam logic [11:0] TV = 12'h5a3, GL = 12'h123, RL = 12'h456, BL = 12'h789;
   // Bar masks, bits red/green/blue, white first
   localparam logic [23:0] CBM = {3'h0, 3'h1, 3'h4, 3'h5, 3'h2, 3'h3, 3'h6, 3'h7};
   logic        i_ref_clk = 0, i_pix_clk = 0, i_nrst = 0;
   logic        i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
   logic [7:0]  i_wb_adr = 8'h00;
   logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
   logic [3:0]  i_wb_sel = 4'h0;
   logic        o_wb_ack, o_frame_valid, o_line_valid, rx_frame_valid, rx_line_valid;
   logic [11:0] sd = 12'h000, o_pix_data, rx_d, pe;
   logic        sfv = 0, slv = 0, sdk = 0;
   logic [11:0] q[$];
   int          error_cnt = 0, checked = 0, tmo = 0;

   initial forever #50 i_ref_clk = ~i_ref_clk;
   initial begin
      #7;
      forever #7.5 i_pix_clk = ~i_pix_clk;
   end

   tpg_core #(.CB_SHIFT(2)) u_tpg_core (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
      .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
      .i_pix_clk(i_pix_clk), .i_sns_data(sd), .i_sns_frame_valid(sfv),
      .i_sns_line_valid(slv), .i_sns_dark(sdk), .o_pix_data(o_pix_data),
      .o_frame_valid(o_frame_valid), .o_line_valid(o_line_valid));
   tpg_rx u_tpg_rx (.i_pix_clk(i_pix_clk), .i_pix_data(o_pix_data),
      .i_frame_valid(o_frame_valid), .i_line_valid(o_line_valid),
      .o_data(rx_d), .o_frame_valid(rx_frame_valid), .o_line_valid(rx_line_valid));

   // ----------------------------------------
   // Stream checking and run control
   // ----------------------------------------
   always @(posedge i_pix_clk) if (rx_line_valid === 1'b1) begin
      `CHK("frame_valid", 1'b1, rx_frame_valid)
      if (q.size() == 0) `CHK("extra", 1'b0, 1'b1)
      else begin
         pe = q.pop_front();
         `CHK("pix", pe, rx_d)
      end
   end

   task automatic final_report();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge i_ref_clk) begin
      tmo++;
      if (tmo == 5000) begin
         error_cnt++;
         final_report();
      end
   end

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} <= {2'b11, we, a, d, 4'h3};
      do @(posedge i_ref_clk); while (o_wb_ack !== 1'b1);
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      @(posedge i_ref_clk);
   endtask

   // Four lines of 34 pixels, first and last dark so every colour of dark is seen
   task automatic frame(input logic [3:0] m, input logic en);
      logic [11:0] cl, e, clv;
      logic [2:0]  k;
      @(posedge i_pix_clk) sfv <= 1'b1;
      for (int r = 0; r < 4; r++) begin
         @(posedge i_pix_clk);
         for (int c = 0; c < 34; c++) begin
            cl  = 12'(c - 1);
            k   = CBM[cl[4:2]*3 +: 3];
            clv = (r[0] == c[0]) ? GL : (r[0] ? BL : RL);
            case (m)
               4'h1: e = cl;
               4'h2: e = 12'(r);
               4'h3: e = cl + 12'(r);
               4'h4: e = cl[0] ? ~TV : TV;
               4'h5: e = 12'h001 << (cl % 12);
               4'h6: e = ((r / 3) % 2) ? BL : GL;
               4'h7: e = ((cl / 3) % 2) ? BL : GL;
               4'h8: e = {12{(r[0] == c[0]) ? k[1] : (r[0] ? k[0] : k[2])}};
               default: e = clv;
            endcase
            if (c == 0 || c == 33) e = clv;
            if (!en) e = {r[3:0], 8'(c)};
            q.push_back(e);
            {sd, slv, sdk} <= {r[3:0], 8'(c), 1'b1, c == 0 || c == 33};
            @(posedge i_pix_clk);
         end
         slv <= 1'b0;
      end
      @(posedge i_pix_clk) sfv <= 1'b0;
      repeat (4) @(posedge i_pix_clk);
      `CHK("left", 0, q.size())
   endtask

   // New settings apply only once the hand-over is done and between frames
   task automatic run(input logic [3:0] m, input logic en);
      wb(1'b1, 8'h00, {24'h0, m, 3'h0, en});
      do wb(1'b0, 8'h18, 32'h0); while (rd[0] !== 1'b0);
      `CHK("stat_enable", en, rd[2])
      `CHK("stat_frame", 1'b0, rd[1])
      frame(m, en);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      wb(1'b1, 8'h04, 32'(TV));
      wb(1'b1, 8'h08, 32'(GL));
      wb(1'b1, 8'h0c, 32'(RL));
      wb(1'b1, 8'h10, 32'(BL));
      wb(1'b1, 8'h14, 32'h3);
      wb(1'b0, 8'h08, 32'h0);
      `CHK("green", 32'(GL), rd)
      wb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped", 32'h0, rd)
   endtask

   task automatic t_pass();     run(4'h4, 1'b0); endtask
   task automatic t_field();
      run(4'h0, 1'b1);
      run(4'h9, 1'b1);
   endtask
   task automatic t_classic();  run(4'h4, 1'b1); endtask
   task automatic t_walk();     run(4'h5, 1'b1); endtask
   task automatic t_cbar();     run(4'h8, 1'b1); endtask
   task automatic t_grad();
      run(4'h1, 1'b1);
      run(4'h2, 1'b1);
      run(4'h3, 1'b1);
   endtask
   task automatic t_bars();
      run(4'h6, 1'b1);
      run(4'h7, 1'b1);
   endtask

   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      t_regs();
      t_pass();
      t_field();
      t_classic();
      t_grad();
      t_walk();
      t_bars();
      t_cbar();
      t_pass();
      final_report();
   end
endmodule // tb_image_test_pattern_generator
